// ===== src/scu_pkg.sv
// constants, register map and field layouts for the serial channel block
// assumes a 32-bit avalon-mm master that drives byte addresses

package scu_pkg;

  // channel order: u0c0, u0c1, u0c2, u0c3, u1c0, u1c1
  localparam int NCH = 6;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;

  // register indices; the byte address is the index times four
  localparam logic [19:0] IDX_CLK_GATE = 20'hF00F0;
  localparam logic [19:0] IDX_STATUS = 20'hF0120;
  localparam logic [19:0] IDX_START = 20'hF0122;
  localparam logic [19:0] IDX_PRESC [2] = '{20'hF0126, 20'hF0166};
  localparam logic [19:0] IDX_MODE [NCH] = '{20'hF0110, 20'hF0112, 20'hF0114, 20'hF0116, 20'hF0150, 20'hF0152};
  localparam logic [19:0] IDX_OPSET [NCH] = '{20'hF0118, 20'hF011A, 20'hF011C, 20'hF011E, 20'hF0158, 20'hF015A};
  localparam logic [19:0] IDX_DATA [NCH] = '{20'hFFF10, 20'hFFF12, 20'hFFF44, 20'hFFF46, 20'hFFF48, 20'hFFF4A};

  // per-channel properties
  localparam logic [NCH-1:0] CH_UNIT1 = 6'h30;  // channels that belong to unit 1
  localparam logic [NCH-1:0] CH_WIDE = 6'h03;   // channels with a 9-bit buffer
  localparam logic [NCH-1:0] CH_TRIG = 6'h2A;   // channels with trigger and invert fields

  // clock gate register
  localparam logic [7:0] GATE_RST = 8'h00;
  localparam logic [7:0] GATE_WMASK = 8'hAD;
  localparam int GATE_U0 = 2;
  localparam int GATE_U1 = 3;

  // mode, operation setting, data and prescaler registers
  localparam logic [15:0] MODE_RST = 16'h0020;
  localparam logic [15:0] MODE_WMASK_TRIG = 16'hC167;
  localparam logic [15:0] MODE_WMASK_PLAIN = 16'hC027;
  localparam logic [15:0] OPSET_RST = 16'h0087;
  localparam logic [15:0] OPSET_WMASK = 16'h0083;
  localparam logic [15:0] OPSET_FIXED_NARROW = 16'h0002;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [8:0] BUF_MASK_WIDE = 9'h1FF;
  localparam logic [8:0] BUF_MASK_NARROW = 9'h0FF;
  localparam logic [7:0] PRESC_RST = 8'h00;

  // data length codes and lengths
  localparam logic [1:0] DLS_9 = 2'b01;
  localparam logic [1:0] DLS_7 = 2'b10;
  localparam logic [3:0] LEN_7 = 4'h7;
  localparam logic [3:0] LEN_8 = 4'h8;
  localparam logic [3:0] LEN_9 = 4'h9;

  typedef enum logic [1:0] {
    MODE_CSI = 2'b00,
    MODE_UART = 2'b01,
    MODE_IIC = 2'b10,
    MODE_BAD = 2'b11
  } scu_opmode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SHIFT = 3'b100
  } scu_state_t;

  // mode register layout
  typedef struct packed {
    logic op_clock_select;
    logic transfer_clock_source;
    logic [4:0] rsv13_9;
    logic start_trigger_select;
    logic rsv7;
    logic rx_invert_select;
    logic fixed_one;
    logic [1:0] rsv4_3;
    logic mode_sel_hi;
    logic mode_sel_lo;
    logic irq_source_select;
  } scu_mode_t;

  // operation setting register layout (only order and length are kept)
  typedef struct packed {
    logic [7:0] rsv15_8;
    logic lsb_first;
    logic [4:0] rsv6_2;
    logic data_len_bit1;
    logic data_len_bit0;
  } scu_opset_t;

endpackage

// ===== src/scu_top.sv
// serial channel array: data buffers, mode registers, clock gates and shift engines
// assumes an avalon-mm master with byte addresses on i_mclk and pins from other clock domains
// Notes on behaviour
// - transmit copies buffer to shifter, shifts it out
// - data register 16 bits, divider bits 15..9
// - received data stored right aligned by length
// - nine bits only on the first pair
// - word access plus low-byte alias access
// - reset clears every data register
// - bits above data length cleared on reception
// - unit gate off: held reset, writes ignored
// - operation clock picks prescaled clock a or b
// - transfer clock: divided clock or serial pin
// - operation clock edge detector, transfer clock shifter
// - odd channels may start on receive edge
// - transfer begins after start and trigger met
// - invert bit picks start edge and uart receive data polarity
// - mode bits 2..1 pick uart; csi and two-wire codes shift alike
// - interrupt source zero: end of transfer
// - interrupt source one: buffer empty on load
// - nine bit shift register, hidden from software
// - length codes: 01 nine (uart on the first pair, else eight), 10 seven, 11 eight
`timescale 1ns/1ps

module scu_top (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // avalon-mm slave
  input wire logic [scu_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [scu_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [scu_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // serial pins
  input wire logic [scu_pkg::NCH-1:0] i_rx_data_pin,
  input wire logic [scu_pkg::NCH-1:0] i_serial_clock_pin,
  output logic [scu_pkg::NCH-1:0] o_tx_data_pin,
  // channel interrupts
  output logic [scu_pkg::NCH-1:0] o_chan_irq
);
  import scu_pkg::*;

  // nine-bit reversal inside the low n bits, upper bits zero
  function automatic logic [8:0] rev_len(input logic [8:0] d, input logic [3:0] n);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        r[i] = d[n - 4'(i) - 4'h1];
      end
    end
    return r;
  endfunction

  // mask of the low n bits
  function automatic logic [8:0] len_mask(input logic [3:0] n);
    return 9'((10'h001 << n) - 10'h001);
  endfunction

  // bus handshake state
  logic wait_reg;        // waitrequest, low for exactly one cycle per request
  logic wr_fire;         // write takes effect this edge
  logic [19:0] word_idx; // register index of the access
  logic [DATA_W-1:0] rd_next;

  // shared registers
  logic [7:0] gate_reg;           // peripheral_clock_gate
  logic [7:0] presc_reg [2];      // unit_prescaler_select per unit
  logic [15:0] presc_cnt_reg;     // free-running prescaler count
  logic [1:0] tick_a;             // prescaled_clock_a tick per unit
  logic [1:0] tick_b;             // prescaled_clock_b tick per unit
  logic [1:0] unit_on;            // unit clock enable per unit
  logic [NCH-1:0] start_pulse;    // chan_start_reg write, one cycle
  logic [NCH-1:0] busy;           // chan_enable_status

  // per-channel register file
  logic [15:0] data_reg [NCH];    // chan_data_reg
  logic [15:0] mode_reg [NCH];    // chan_mode_reg
  logic [15:0] opset_reg [NCH];   // chan_op_setting_reg

  assign wr_fire = i_avs_write && !wait_reg;
  assign word_idx = i_avs_address[ADDR_W-1:2];
  assign unit_on = {gate_reg[GATE_U1], gate_reg[GATE_U0]};

  // waitrequest drops one cycle after a request and rises again after the answer
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wait_reg <= 1'b1;
    end else if (wait_reg && (i_avs_read || i_avs_write)) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end
  assign o_avs_waitrequest = wait_reg;

  // read data is registered while waitrequest is still high, so it stands at the answer edge
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_avs_readdata <= '0;
    end else if (wait_reg && i_avs_read) begin
      o_avs_readdata <= rd_next;
    end
  end

  // read decode; unmapped addresses read as zero
  always_comb begin
    rd_next = '0;
    if (word_idx == IDX_CLK_GATE) begin
      rd_next = {24'h000000, gate_reg};
    end else if (word_idx == IDX_STATUS) begin
      rd_next = {26'h0000000, busy};
    end else if (word_idx == IDX_PRESC[0]) begin
      rd_next = {24'h000000, presc_reg[0]};
    end else if (word_idx == IDX_PRESC[1]) begin
      rd_next = {24'h000000, presc_reg[1]};
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (word_idx == IDX_DATA[c]) begin
          rd_next = {16'h0000, data_reg[c]};
        end else if (word_idx == IDX_MODE[c]) begin
          rd_next = {16'h0000, mode_reg[c]};
        end else if (word_idx == IDX_OPSET[c]) begin
          rd_next = {16'h0000, opset_reg[c]};
        end
      end
    end
  end

  // clock gate register; bits 1, 4 and 6 always stay zero, bits 0, 5 and 7 stay writable
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      gate_reg <= GATE_RST;
    end else if (wr_fire && word_idx == IDX_CLK_GATE && i_avs_byteenable[0]) begin
      gate_reg <= i_avs_writedata[7:0] & GATE_WMASK;
    end
  end

  // prescaler select per unit, held reset and write-locked while the unit is gated
  always_ff @(posedge i_mclk) begin
    for (int u = 0; u < 2; u++) begin
      if (i_sys_rst || !unit_on[u]) begin
        presc_reg[u] <= PRESC_RST;
      end else if (wr_fire && word_idx == IDX_PRESC[u] && i_avs_byteenable[0]) begin
        presc_reg[u] <= i_avs_writedata[7:0];
      end
    end
  end

  // shared prescaler counter; each select nibble divides by two to its power
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      presc_cnt_reg <= 16'h0000;
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 16'h0001;
    end
  end

  // prescaled tick per unit; select value zero ticks every cycle
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      tick_a[u] = (presc_cnt_reg & (16'hFFFF >> (5'd16 - {1'b0, presc_reg[u][3:0]})))
                  == (16'hFFFF >> (5'd16 - {1'b0, presc_reg[u][3:0]}));
      tick_b[u] = (presc_cnt_reg & (16'hFFFF >> (5'd16 - {1'b0, presc_reg[u][7:4]})))
                  == (16'hFFFF >> (5'd16 - {1'b0, presc_reg[u][7:4]}));
    end
  end

  // start register: writing one requests a transfer on that channel
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      start_pulse <= '0;
    end else if (wr_fire && word_idx == IDX_START && i_avs_byteenable[0]) begin
      for (int c = 0; c < NCH; c++) begin
        start_pulse[c] <= i_avs_writedata[c] && unit_on[CH_UNIT1[c]];
      end
    end else begin
      start_pulse <= '0;
    end
  end

  // one engine per channel
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam bit WIDE = CH_WIDE[c];
    localparam bit TRIG = CH_TRIG[c];
    localparam int UNIT = CH_UNIT1[c] ? 1 : 0;

    logic rst_ch;            // system reset or unit gated off
    scu_mode_t mode;         // decoded mode register
    scu_opset_t opset;       // decoded operation setting
    logic uart;              // asynchronous mode selected
    logic [3:0] len;         // data length in bits
    logic [3:0] last_pos;    // last bit position of a frame
    logic [8:0] buf_mask;    // buffer bits that exist on this channel
    logic op_tick;           // operation clock tick
    logic t_tick;            // transfer clock tick
    logic [7:0] div_cnt_reg; // operation clock divider
    logic int_tick_reg;      // divided transfer tick
    logic [2:0] rx_sync_reg; // receive pin synchroniser and history
    logic [2:0] sck_sync_reg;// serial clock pin synchroniser and history
    logic rx_last_reg;       // receive level seen at the previous operation tick
    logic start_edge;        // valid start edge on the receive pin
    scu_state_t state_reg;
    logic [8:0] shift_reg;   // hidden shift register
    logic [3:0] pos_reg;     // bit position within the frame
    logic store_reg;         // received data goes to the buffer next edge
    logic [8:0] rx_value;    // received data ready for the buffer
    logic [8:0] ld_value;    // buffer ready for the shifter
    logic data_pos;          // position carries a data bit
    logic tx_bit;            // level to drive at this position

    assign rst_ch = i_sys_rst || !unit_on[UNIT];
    assign mode = scu_mode_t'(mode_reg[c]);
    assign opset = scu_opset_t'(opset_reg[c]);
    assign uart = {mode.mode_sel_hi, mode.mode_sel_lo} == MODE_UART;
    assign buf_mask = WIDE ? BUF_MASK_WIDE : BUF_MASK_NARROW;

    // length decode; nine bits only in uart mode on wide channels
    always_comb begin
      if ({opset.data_len_bit1, opset.data_len_bit0} == DLS_7) begin
        len = LEN_7;
      end else if ({opset.data_len_bit1, opset.data_len_bit0} == DLS_9 && WIDE && uart) begin
        len = LEN_9;
      end else begin
        len = LEN_8;
      end
    end

    // uart frames carry a start and a stop bit around the data
    assign last_pos = uart ? len + 4'h1 : len - 4'h1;
    assign data_pos = uart ? (pos_reg != 4'h0 && pos_reg <= len) : 1'b1;
    assign tx_bit = (uart && pos_reg == 4'h0) ? 1'b0 : (uart && pos_reg > len) ? 1'b1 : shift_reg[0];

    // operation clock choice between the two prescaled ticks
    assign op_tick = mode.op_clock_select ? tick_b[UNIT] : tick_a[UNIT];

    // pin synchronisers; the second stage is read, the third only on the serial clock pin
    always_ff @(posedge i_mclk) begin
      if (rst_ch) begin
        rx_sync_reg <= 3'b111;
        sck_sync_reg <= 3'b000;
      end else begin
        rx_sync_reg <= {rx_sync_reg[1:0], i_rx_data_pin[c]};
        sck_sync_reg <= {sck_sync_reg[1:0], i_serial_clock_pin[c]};
      end
    end

    // divider: one transfer tick per 2*(ratio+1) operation ticks
    always_ff @(posedge i_mclk) begin
      if (rst_ch) begin
        div_cnt_reg <= 8'h00;
        int_tick_reg <= 1'b0;
      end else if (state_reg != ST_SHIFT) begin
        // parked half a bit in, so the first tick of a frame lands mid start bit
        div_cnt_reg <= {1'b0, data_reg[c][15:9]} + 8'h01;
        int_tick_reg <= 1'b0;
      end else if (op_tick) begin
        int_tick_reg <= div_cnt_reg == {data_reg[c][15:9], 1'b1};
        div_cnt_reg <= (div_cnt_reg == {data_reg[c][15:9], 1'b1}) ? 8'h00 : div_cnt_reg + 8'h01;
      end else begin
        int_tick_reg <= 1'b0;
      end
    end

    // transfer clock: divided clock or rising edge on the serial clock pin
    assign t_tick = mode.transfer_clock_source ? (sck_sync_reg[1] && !sck_sync_reg[2]) : int_tick_reg;

    // edge detector runs on the operation clock; invert picks falling or rising
    always_ff @(posedge i_mclk) begin
      if (rst_ch) begin
        rx_last_reg <= 1'b1;
      end else if (op_tick) begin
        rx_last_reg <= rx_sync_reg[1];
      end
    end
    assign start_edge = op_tick && (mode.rx_invert_select ? (!rx_last_reg && rx_sync_reg[1])
                                                          : (rx_last_reg && !rx_sync_reg[1]));

    // buffer into shifter order, and shifter back to right-aligned data
    assign ld_value = opset.lsb_first ? (data_reg[c][8:0] & len_mask(len)) : rev_len(data_reg[c][8:0], len);
    always_comb begin
      rx_value = shift_reg >> (4'h9 - len);
      if (!opset.lsb_first) begin
        rx_value = rev_len(rx_value, len);
      end
      if (uart && mode.rx_invert_select) begin
        rx_value = ~rx_value;
      end
      rx_value = rx_value & len_mask(len) & buf_mask;
    end

    // channel sequencer: wait for start, optional edge trigger, then shift
    always_ff @(posedge i_mclk) begin
      if (rst_ch) begin
        state_reg <= ST_IDLE;
        shift_reg <= 9'h000;
        pos_reg <= 4'h0;
        store_reg <= 1'b0;
        o_tx_data_pin[c] <= 1'b1;
        o_chan_irq[c] <= 1'b0;
      end else begin
        store_reg <= 1'b0;
        o_chan_irq[c] <= 1'b0;
        case (state_reg)
          ST_IDLE: begin
            if (start_pulse[c] && TRIG && mode.start_trigger_select) begin
              state_reg <= ST_WAIT;
            end else if (start_pulse[c]) begin
              state_reg <= ST_SHIFT;
              shift_reg <= ld_value;
              pos_reg <= 4'h0;
              o_chan_irq[c] <= mode.irq_source_select;
            end
          end
          ST_WAIT: begin
            if (start_edge) begin
              state_reg <= ST_SHIFT;
              shift_reg <= ld_value;
              pos_reg <= 4'h0;
              o_chan_irq[c] <= mode.irq_source_select;
            end
          end
          ST_SHIFT: begin
            if (t_tick) begin
              o_tx_data_pin[c] <= tx_bit;
              if (data_pos) begin
                shift_reg <= {rx_sync_reg[1], shift_reg[8:1]};
              end
              pos_reg <= pos_reg + 4'h1;
              if (pos_reg == last_pos) begin
                state_reg <= ST_IDLE;
                store_reg <= 1'b1;
                o_chan_irq[c] <= !mode.irq_source_select;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
    assign busy[c] = state_reg != ST_IDLE;

    // data register: reception store wins over a bus write in the same cycle
    always_ff @(posedge i_mclk) begin
      if (rst_ch) begin
        data_reg[c] <= DATA_RST;
      end else if (store_reg) begin
        data_reg[c][8:0] <= rx_value | (data_reg[c][8:0] & ~buf_mask);
      end else if (wr_fire && word_idx == IDX_DATA[c]) begin
        if (i_avs_byteenable[0]) begin
          data_reg[c][7:0] <= i_avs_writedata[7:0];
        end
        if (i_avs_byteenable[1]) begin
          data_reg[c][15:8] <= {i_avs_writedata[15:9], i_avs_writedata[8] & buf_mask[8]};
        end
      end
    end

    // mode and operation setting registers; reset loads fixed values, but writes can clear mode bit 5 and clear opset bit 2
    always_ff @(posedge i_mclk) begin
      if (rst_ch) begin
        mode_reg[c] <= MODE_RST;
        opset_reg[c] <= WIDE ? OPSET_RST : (OPSET_RST | OPSET_FIXED_NARROW);
      end else if (wr_fire && &i_avs_byteenable[1:0]) begin
        if (word_idx == IDX_MODE[c]) begin
          mode_reg[c] <= i_avs_writedata[15:0] & (TRIG ? MODE_WMASK_TRIG : MODE_WMASK_PLAIN);
        end
        if (word_idx == IDX_OPSET[c]) begin
          opset_reg[c] <= (i_avs_writedata[15:0] & OPSET_WMASK) | (WIDE ? 16'h0000 : OPSET_FIXED_NARROW);
        end
      end
    end
  end

endmodule

// ===== tb/scu_checker.sv
// port assertions for the serial channel block
// assumes one clock, synchronous reset; bound to scu_top
`timescale 1ns/1ps
module scu_checker (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // register bus
  input wire logic [scu_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [scu_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [scu_pkg::DATA_W-1:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // pins and interrupts
  input wire logic [scu_pkg::NCH-1:0] i_rx_data_pin,
  input wire logic [scu_pkg::NCH-1:0] i_serial_clock_pin,
  input wire logic [scu_pkg::NCH-1:0] o_tx_data_pin,
  input wire logic [scu_pkg::NCH-1:0] o_chan_irq
);
  import scu_pkg::*;
  logic wr_done; // write answered
  logic rd_done; // read answered
  logic [7:0] gate_reg; // gate shadow
  logic [NCH-1:0] live; // channels whose unit runs
  logic [NCH-1:0] started_reg; // channels that got a start
  assign wr_done = i_avs_write & ~o_avs_waitrequest;
  assign rd_done = i_avs_read & ~o_avs_waitrequest;
  assign live = {{2{gate_reg[GATE_U1]}}, {4{gate_reg[GATE_U0]}}};
  // gate shadow follows answered writes only
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      gate_reg <= GATE_RST;
    end else if (wr_done && i_avs_address[21:2] == IDX_CLK_GATE && i_avs_byteenable[0]) begin
      gate_reg <= i_avs_writedata[7:0] & GATE_WMASK;
    end
  end
  // channels ever started
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      started_reg <= '0;
    end else if (wr_done && i_avs_address[21:2] == IDX_START && i_avs_byteenable[0]) begin
      started_reg <= started_reg | i_avs_writedata[NCH-1:0];
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  chk_wait_one_cycle: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
    else $error("wait low too long");
  chk_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("no answer");
  chk_no_stray_answer: assert property (!o_avs_waitrequest |-> $past(i_avs_read || i_avs_write))
    else $error("stray answer");
  chk_read_upper_zero: assert property (rd_done |-> o_avs_readdata[31:16] == 16'h0)
    else $error("upper read bits set");
  chk_unmapped_read: assert property (rd_done && i_avs_address[21:2] < IDX_CLK_GATE |-> o_avs_readdata == '0)
    else $error("unmapped read");
  chk_gate_readback: assert property (rd_done && i_avs_address[21:2] == IDX_CLK_GATE
      |-> o_avs_readdata == 32'(gate_reg))
    else $error("gate readback");
  chk_tx_idle_reset: assert property ($fell(i_sys_rst) |-> o_tx_data_pin == '1)
    else $error("tx not idle");
  chk_irq_one_cycle: assert property ((o_chan_irq & $past(o_chan_irq)) == '0)
    else $error("irq too long");
  chk_gated_irq_quiet: assert property ((o_chan_irq & ~(live | $past(live))) == '0)
    else $error("gated irq");
  chk_gated_tx_idle: assert property ((~o_tx_data_pin & ~(live | $past(live))) == '0)
    else $error("gated tx");
  chk_tx_after_start: assert property ((~o_tx_data_pin & ~started_reg) == '0)
    else $error("tx before start");
  cov_read: cover property (rd_done && i_avs_address[21:2] == IDX_CLK_GATE);
  cov_irq: cover property (o_chan_irq[1]);
  cov_tx: cover property ($fell(o_tx_data_pin[0]));
endmodule
bind scu_top scu_checker chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_rx_data_pin(i_rx_data_pin), .i_serial_clock_pin(i_serial_clock_pin), .o_tx_data_pin(o_tx_data_pin),
  .o_chan_irq(o_chan_irq));

// ===== tb/scu_far_end.sv
// far-end serial device: captures frames from a tx pin, sends frames on an rx pin
// assumes lsb-first frames with start and stop bit
`timescale 1ns/1ps
module scu_far_end #(
  parameter int BIT_CYC = 16
) (
  // clock
  input wire logic i_mclk,
  // pins seen from the far side
  input wire logic [scu_pkg::NCH-1:0] i_tx_data_pin,
  output logic [scu_pkg::NCH-1:0] o_rx_data_pin,
  output logic [scu_pkg::NCH-1:0] o_serial_clock_pin
);
  import scu_pkg::*;
  logic stop_seen; // stop level of the last captured frame
  // lines idle high, clock pin low
  initial begin
    o_rx_data_pin = '1;
    o_serial_clock_pin = '0;
    stop_seen = 1'b0;
  end
  // sample mid-bit, timed from the start edge
  task automatic grab(input int ch, input int len, output logic [8:0] d);
    int n;
    n = 0;
    d = '0;
    while (i_tx_data_pin[ch] !== 1'b0 && n < 4000) begin
      @(posedge i_mclk);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge i_mclk);
    for (int i = 0; i < len; i++) begin
      repeat (BIT_CYC) @(posedge i_mclk);
      d[i] = i_tx_data_pin[ch];
    end
    repeat (BIT_CYC) @(posedge i_mclk);
    stop_seen = i_tx_data_pin[ch];
  endtask
  // idle level first, then the frame
  task automatic send(input int ch, input int len, input logic [8:0] d, input logic inv);
    @(posedge i_mclk);
    o_rx_data_pin[ch] <= ~inv;
    repeat (4 * BIT_CYC) @(posedge i_mclk);
    for (int i = 0; i < len + 2; i++) begin
      o_rx_data_pin[ch] <= ((i == 0) ? 1'b0 : (i > len) ? 1'b1 : d[i-1]) ^ inv;
      repeat (BIT_CYC) @(posedge i_mclk);
    end
    o_rx_data_pin[ch] <= 1'b1;
  endtask
endmodule

// ===== tb/tb_top.sv
// bench for scu_top: register map, uart transmit and receive, mid-run reset
// assumes scu_far_end on the pins and the bound checker
`timescale 1ns/1ps
module tb_top;
  import scu_pkg::*;
  typedef struct packed {
    logic wr;
    logic [19:0] idx;
    logic [15:0] d;
    logic [15:0] exp;
  } scu_row_t;
  logic mclk, sys_rst, av_rd, av_wr, av_wait;
  logic [ADDR_W-1:0] av_addr;
  logic [DATA_W-1:0] av_wdata, av_rdata;
  logic [3:0] av_be;
  logic [NCH-1:0] rx_pin, sck_pin, tx_pin, irq;
  int num_errors = 0;
  int compares = 0;
  int irq_cnt [2] = '{0, 0};
  // register cases
  scu_row_t rows [13] = '{
    '{1'b0, IDX_CLK_GATE, 16'h0, 16'h0},
    '{1'b0, IDX_DATA[0], 16'h0, 16'h0},
    '{1'b0, IDX_MODE[5], 16'h0, 16'h0020},
    '{1'b1, IDX_DATA[0], 16'h1234, 16'h0},
    '{1'b0, IDX_DATA[0], 16'h0, 16'h0},
    '{1'b1, IDX_CLK_GATE, 16'h000C, 16'h0},
    '{1'b0, IDX_CLK_GATE, 16'h0, 16'h000C},
    '{1'b1, IDX_DATA[0], 16'hFFFF, 16'h0},
    '{1'b0, IDX_DATA[0], 16'h0, 16'hFFFF},
    '{1'b1, IDX_DATA[2], 16'hFE5A, 16'h0},
    '{1'b0, IDX_DATA[2], 16'h0, 16'hFE5A},
    '{1'b0, 20'hF0000, 16'h0, 16'h0},
    '{1'b1, IDX_MODE[5], 16'h8123, 16'h0}
  };
  scu_top uut (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_avs_address(av_addr), .i_avs_read(av_rd),
    .i_avs_write(av_wr), .i_avs_writedata(av_wdata), .i_avs_byteenable(av_be), .o_avs_readdata(av_rdata),
    .o_avs_waitrequest(av_wait), .i_rx_data_pin(rx_pin), .i_serial_clock_pin(sck_pin),
    .o_tx_data_pin(tx_pin), .o_chan_irq(irq));
  scu_far_end far (.i_mclk(mclk), .i_tx_data_pin(tx_pin), .o_rx_data_pin(rx_pin), .o_serial_clock_pin(sck_pin));
  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // count pulses, one per high cycle
  always @(posedge mclk) begin
    if (irq[0] === 1'b1) irq_cnt[0] <= irq_cnt[0] + 1;
    if (irq[1] === 1'b1) irq_cnt[1] <= irq_cnt[1] + 1;
  end
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one transfer, held until waitrequest low
  task automatic bus(input logic wr, input logic [19:0] idx, input logic [15:0] d, input logic [3:0] be,
                     output logic [15:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    av_addr <= {idx, 2'b00};
    av_rd <= ~wr;
    av_wr <= wr;
    av_wdata <= 32'(d);
    av_be <= be;
    do begin
      @(posedge mclk);
      n++;
    end while (av_wait !== 1'b0 && n < 50);
    q = av_rdata[15:0];
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    check("wait", 16'h0, 16'(av_wait));
  endtask
  // channel 0 frame; early: load interrupt and byte write
  task automatic tx_frame(input logic [15:0] mode, input logic [7:0] exp, input logic early);
    int base;
    logic [15:0] q;
    logic [8:0] got;
    bus(1'b1, IDX_MODE[0], mode, 4'h3, q);
    bus(1'b1, IDX_DATA[0], {8'h0E, exp}, 4'h3, q);
    base = irq_cnt[0];
    fork
      far.grab(0, 8, got);
      begin
        bus(1'b1, IDX_START, 16'h0001, 4'h3, q);
        repeat (6) @(posedge mclk);
        check("irq at load", 16'(base + early), 16'(irq_cnt[0]));
        if (early) begin
          bus(1'b1, IDX_DATA[0], 16'h003C, 4'h1, q);
          bus(1'b0, IDX_DATA[0], 16'h0, 4'h3, q);
          check("alias", 16'h0E3C, q);
        end
      end
    join
    repeat (40) @(posedge mclk);
    check("tx data", 16'(exp), 16'(got));
    check("stop bit", 16'h0001, 16'(far.stop_seen));
    check("tx irq", 16'(base + 1), 16'(irq_cnt[0]));
    $display("transmit test done");
  endtask
  // channel 1 frame started by a receive edge
  task automatic rx_frame(input logic [15:0] mode, input logic [15:0] opset, input int len,
                          input logic [7:0] val, input logic inv, input logic [15:0] exp);
    int base;
    logic [15:0] q;
    bus(1'b1, IDX_MODE[1], mode, 4'h3, q);
    bus(1'b1, IDX_OPSET[1], opset, 4'h3, q);
    bus(1'b1, IDX_DATA[1], 16'h0FFF, 4'h3, q);
    base = irq_cnt[1];
    bus(1'b1, IDX_START, 16'h0002, 4'h3, q);
    far.send(1, len, {1'b0, val}, inv);
    repeat (40) @(posedge mclk);
    bus(1'b0, IDX_DATA[1], 16'h0, 4'h3, q);
    check("rx data", exp, q);
    check("rx irq", 16'(base + 1), 16'(irq_cnt[1]));
    $display("receive test done");
  endtask
  task automatic close_out();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog: all tests together need under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    close_out();
  end
  initial begin
    logic [15:0] q;
    sys_rst = 1'b1;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_addr = '0;
    av_wdata = '0;
    av_be = 4'h0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].idx, rows[i].d, 4'h3, q);
      if (!rows[i].wr) check("reg", rows[i].exp, q);
    end
    $display("register test done");
    tx_frame(16'h0022, 8'hA5, 1'b0);
    tx_frame(16'h0023, 8'hA5, 1'b1);
    tx_frame(16'h0022, 8'h3C, 1'b0);
    rx_frame(16'h0122, 16'h0086, 7, 8'hD3, 1'b0, 16'h0E53);
    rx_frame(16'h0162, 16'h0087, 8, 8'hC6, 1'b1, 16'h0EC6);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(1'b0, IDX_CLK_GATE, 16'h0, 4'h3, q);
    check("gate", 16'h0, q);
    bus(1'b1, IDX_CLK_GATE, 16'h000C, 4'h3, q);
    bus(1'b0, IDX_DATA[1], 16'h0, 4'h3, q);
    check("data", 16'h0, q);
    $display("reset test done");
    close_out();
  end
endmodule
